// [hdl/mrx_pkg.sv]
package mrx_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [11:0] MRX_CTRL2_OFS = 12'h000;
   localparam logic [11:0] MRX_BUF_OFS = 12'h004;
   localparam logic [11:0] MRX_STAT_OFS = 12'h008;
   localparam logic [11:0] MRX_IRQ_OFS = 12'h00C;
   localparam logic [11:0] MRX_MASK_OFS = 12'h010;
   localparam logic [11:0] MRX_BAUD_OFS = 12'h014;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int MRX_RECEIVE_ENABLE_BIT_BIT = 3;
   localparam int MRX_ACK_SEQUENCE_ENABLE_BIT = 4;
   localparam int MRX_BF_BIT = 0;
   localparam int MRX_OV_BIT = 1;
   localparam int MRX_WRITE_COLLISION_FLAG_BIT = 2;
   localparam int MRX_BUSY_BIT = 3;
   localparam int MRX_IRQ_BITS = 3;

   // ---------------------------------------------------------------
   // Reset values and timing
   // ---------------------------------------------------------------
   localparam logic [7:0] MRX_BAUD_RST = 8'h04;
   localparam logic [MRX_IRQ_BITS-1:0] MRX_MASK_RST = 3'h0;
   localparam int MRX_BITS_PER_BYTE = 8;

   // Event sources feeding the sticky status register.
   typedef struct packed {
      logic write_collision_flag;
      logic ovf;
      logic rxdone;
   } mrx_evt_t;

   typedef enum logic [1:0] {
      MRX_IDLE = 2'b00,
      MRX_LOW = 2'b01,
      MRX_HIGH = 2'b11
   } mrx_state_t;

endpackage : mrx_pkg

// [hdl/mrx_sync.sv]
module mrx_sync
   import mrx_pkg::*;
#(
   parameter int WIDTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;

   // ---------------------------------------------------------------
   // Two-stage synchroniser; the first stage feeds only the second.
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '1;
         q <= '1;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule : mrx_sync

// [hdl/mrx_receiver.sv]
// Behaviour
// - A receive-enable write is ignored unless the port is idle.
// - Each baud rollover toggles the clock; only a high-phase rollover shifts in a bit.
// - After eighth falling edge: clear enable, load buffer unless full, set flags.
// - After a byte the counter stops and the clock stays low.
// - Reading the buffer clears the buffer-full flag.
// - Buffer-full is set whenever a received byte moves into the buffer; a software buffer write leaves it unchanged.
// - Overflow is set when a byte completes while buffer-full is set.
// - Buffer write during reception sets collision and is dropped.
//
// Local design decisions: the address map and register access over APB.
module mrx_receiver
   import mrx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic ack_sequence_enable,
   output logic irq
);

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      return a == o;
   endfunction : hit

   logic wr_en;
   logic rd_en;
   logic mapped;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign mapped = hit(paddr, MRX_CTRL2_OFS) || hit(paddr, MRX_BUF_OFS) ||
      hit(paddr, MRX_STAT_OFS) || hit(paddr, MRX_IRQ_OFS) ||
      hit(paddr, MRX_MASK_OFS) || hit(paddr, MRX_BAUD_OFS);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] pins_s;
   mrx_sync #(.WIDTH(2)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d({scl_in, sda_in}),
      .q(pins_s)
   );

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   mrx_state_t state_r;
   logic receive_enable_bit_r;
   logic ack_r;
   logic [7:0] baud_r;
   logic [7:0] brg_r;
   logic [3:0] bitcnt_r;
   logic [7:0] serial_shift_register_r;
   logic [7:0] serial_buffer_r;
   logic buffer_full_flag_r;
   logic write_collision_flag_r;
   logic [MRX_IRQ_BITS-1:0] stat_r;
   logic [MRX_IRQ_BITS-1:0] mask_r;
   mrx_evt_t evt;
   logic rollover;
   logic byte_done;
   logic start_rx;
   logic buf_rd;
   logic buf_wr;
   logic [7:0] shift_nxt;

   assign rollover = (state_r != MRX_IDLE) && (brg_r == 8'h00);
   assign byte_done = rollover && (state_r == MRX_HIGH) &&
      (bitcnt_r == 4'(MRX_BITS_PER_BYTE - 1));
   assign start_rx = wr_en && hit(paddr, MRX_CTRL2_OFS) &&
      pwdata[MRX_RECEIVE_ENABLE_BIT_BIT] && (state_r == MRX_IDLE);
   assign buf_rd = rd_en && hit(paddr, MRX_BUF_OFS);
   assign buf_wr = wr_en && hit(paddr, MRX_BUF_OFS);
   assign shift_nxt = {serial_shift_register_r[6:0], pins_s[0]};

   assign evt.rxdone = byte_done;
   assign evt.ovf = byte_done && buffer_full_flag_r;
   assign evt.write_collision_flag = buf_wr && (state_r != MRX_IDLE);

   // ---------------------------------------------------------------
   // Receive sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= MRX_IDLE;
         brg_r <= 8'h00;
         bitcnt_r <= 4'h0;
         serial_shift_register_r <= 8'h00;
      end else if (ce) begin
         case (state_r)
            MRX_IDLE: begin
               if (start_rx) begin
                  state_r <= MRX_LOW;
                  brg_r <= baud_r;
                  bitcnt_r <= 4'h0;
               end
            end
            MRX_LOW: begin
               if (rollover) begin
                  state_r <= MRX_HIGH;
                  brg_r <= baud_r;
               end else begin
                  brg_r <= brg_r - 8'h01;
               end
            end
            MRX_HIGH: begin
               if (rollover) begin
                  // Sample at the end of the high phase, just before fall.
                  serial_shift_register_r <= shift_nxt;
                  brg_r <= baud_r;
                  if (byte_done) begin
                     state_r <= MRX_IDLE;
                  end else begin
                     state_r <= MRX_LOW;
                     bitcnt_r <= bitcnt_r + 4'h1;
                  end
               end else begin
                  brg_r <= brg_r - 8'h01;
               end
            end
            default: begin
               state_r <= MRX_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Control-two register
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         receive_enable_bit_r <= 1'b0;
         ack_r <= 1'b0;
         baud_r <= MRX_BAUD_RST;
      end else if (ce) begin
         if (byte_done) begin
            receive_enable_bit_r <= 1'b0;
         end else if (start_rx) begin
            receive_enable_bit_r <= 1'b1;
         end
         if (wr_en && hit(paddr, MRX_CTRL2_OFS)) begin
            ack_r <= pwdata[MRX_ACK_SEQUENCE_ENABLE_BIT];
         end
         if (wr_en && hit(paddr, MRX_BAUD_OFS)) begin
            baud_r <= pwdata[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Receive buffer and its flags
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_buffer_r <= 8'h00;
         buffer_full_flag_r <= 1'b0;
      end else if (ce) begin
         if (byte_done && !buffer_full_flag_r) begin
            serial_buffer_r <= shift_nxt;
            buffer_full_flag_r <= 1'b1;
         end else if (buf_rd) begin
            buffer_full_flag_r <= 1'b0;
         end else if (buf_wr && state_r == MRX_IDLE) begin
            serial_buffer_r <= pwdata[7:0];
         end
      end
   end

   // Collision is sticky; only a software write of one clears it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_collision_flag_r <= 1'b0;
      end else if (ce) begin
         if (evt.write_collision_flag) begin
            write_collision_flag_r <= 1'b1;
         end else if (wr_en && hit(paddr, MRX_STAT_OFS) &&
                      pwdata[MRX_WRITE_COLLISION_FLAG_BIT]) begin
            write_collision_flag_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status and mask
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= '0;
      end else if (ce) begin
         // A new event wins over a same-cycle write-one-to-clear.
         if (wr_en && hit(paddr, MRX_IRQ_OFS)) begin
            stat_r <= (stat_r & ~pwdata[MRX_IRQ_BITS-1:0]) | evt;
         end else begin
            stat_r <= stat_r | evt;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= MRX_MASK_RST;
      end else if (ce && wr_en && hit(paddr, MRX_MASK_OFS)) begin
         mask_r <= pwdata[MRX_IRQ_BITS-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         // A set mask bit keeps its status bit off the interrupt line.
         irq <= |(stat_r & ~mask_r);
      end
   end

   // ---------------------------------------------------------------
   // Pins: open drain, pull low only
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_oe <= 1'b0;
      end else if (ce) begin
         // Hold the clock low whenever not in the released high phase.
         scl_oe <= !(state_r == MRX_HIGH);
      end
   end
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign sda_oe = 1'b0;
   assign ack_sequence_enable = ack_r;

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (ce && psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         case (paddr)
            MRX_CTRL2_OFS: begin
               prdata[MRX_RECEIVE_ENABLE_BIT_BIT] <= receive_enable_bit_r;
               prdata[MRX_ACK_SEQUENCE_ENABLE_BIT] <= ack_r;
            end
            MRX_BUF_OFS: prdata[7:0] <= serial_buffer_r;
            MRX_STAT_OFS: begin
               prdata[MRX_BF_BIT] <= buffer_full_flag_r;
               prdata[MRX_OV_BIT] <= stat_r[1];
               prdata[MRX_WRITE_COLLISION_FLAG_BIT] <= write_collision_flag_r;
               prdata[MRX_BUSY_BIT] <= state_r != MRX_IDLE;
            end
            MRX_IRQ_OFS: prdata[MRX_IRQ_BITS-1:0] <= stat_r;
            MRX_MASK_OFS: prdata[MRX_IRQ_BITS-1:0] <= mask_r;
            MRX_BAUD_OFS: prdata[7:0] <= baud_r;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule : mrx_receiver

// [sim/mrx_props.sv]
module mrx_props
   import mrx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic ack_sequence_enable,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // Shadow state
   // ---------------------------------------------------------------
   logic acc;
   logic wr;
   logic mapped;
   logic mask_r;
   logic [7:0] baud_r;
   logic [7:0] low_r;
   logic [3:0] nfall_r;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign mapped = paddr <= MRX_BAUD_OFS && paddr[1:0] == 2'b00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_r <= MRX_BAUD_RST;
         mask_r <= MRX_MASK_RST[0];
      end else if (wr && ce && paddr == MRX_BAUD_OFS) begin
         baud_r <= pwdata[7:0];
      end else if (wr && ce && paddr == MRX_MASK_OFS) begin
         mask_r <= pwdata[0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_r <= 8'h00;
      end else begin
         low_r <= scl_oe ? 8'h00 : low_r + 8'h01;
      end
   end
   // Counting released phases lets the parked clock be told from a bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nfall_r <= 4'h0;
      end else if ($fell(scl_oe)) begin
         nfall_r <= nfall_r + 4'h1;
      end else if ($rose(scl_oe) && nfall_r == 4'h8) begin
         nfall_r <= 4'h0;
      end
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_parked;
      $rose(scl_oe) && nfall_r == 4'h8;
   endsequence
   property p_ready;
      acc |-> pready;
   endproperty
   property p_err;
      acc |-> pslverr == !mapped;
   endproperty
   property p_sda;
      !sda_oe;
   endproperty
   property p_half;
      $rose(scl_oe) && nfall_r != 4'h0 |-> low_r == baud_r + 8'h01;
   endproperty
   property p_eight;
      $fell(scl_oe) |-> nfall_r < 4'h8;
   endproperty
   property p_stop;
      s_parked |=> scl_oe [*4];
   endproperty
   property p_irq;
      s_parked ##0 !mask_r |-> ##[0:3] irq;
   endproperty
   property p_ack;
      wr && ce && paddr == MRX_CTRL2_OFS
         |=> ack_sequence_enable == $past(pwdata[MRX_ACK_SEQUENCE_ENABLE_BIT]);
   endproperty
   property p_prd;
      $changed(prdata) |-> $past(psel && !penable);
   endproperty
   a_ready: assert property (p_ready) else $error("no ready in access");
   a_err: assert property (p_err) else $error("bad slave error");
   a_sda: assert property (p_sda) else $error("data line driven");
   a_half: assert property (p_half) else $error("bad phase");
   a_eight: assert property (p_eight) else $error("ninth clock");
   a_stop: assert property (p_stop) else $error("clock not parked");
   a_irq: assert property (p_irq) else $error("no interrupt");
   a_ack: assert property (p_ack) else $error("ack bit wrong");
   a_prd: assert property (p_prd) else $error("read data moved");
endmodule : mrx_props

bind mrx_receiver mrx_props u_props (
   .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .scl_oe, .sda_oe, .ack_sequence_enable, .irq
);

// [sim/mrx_slave.sv]
module mrx_slave (
   input wire logic scl,
   input wire logic go,
   input wire logic [7:0] data,
   output logic sda_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   int idx = -1;
   // Bits change only after a falling clock, so the line is settled all
   // through the high phase where the master samples.
   always @(posedge go or negedge scl) begin
      if (go) begin
         idx <= 7;
      end else if (idx >= 0) begin
         idx <= idx - 1;
      end
   end
   assign sda_oe = idx >= 0 && !data[idx[2:0]];
endmodule : mrx_slave

// [sim/tb.sv]
module tb
   import mrx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic ce;
   logic scl_out, scl_oe, sda_out, sda_oe, ack, irq, slv_oe, go;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [7:0] slv_byte;
   wire scl, sda;
   int errors, n_compared;
   // Both lines have pull-ups: released means high.
   assign scl = !scl_oe;
   assign sda = !(sda_oe || slv_oe);
   mrx_receiver dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .ack_sequence_enable(ack), .irq(irq)
   );
   mrx_slave u_slave (.scl(scl), .go(go), .data(slv_byte), .sda_oe(slv_oe));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
         tally_and_finish();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask : rd
   task automatic rx(input logic [7:0] b, input logic col);
      int n;
      slv_byte <= b;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      apb(1'b1, MRX_CTRL2_OFS, 32'h8);
      if (col) begin
         apb(1'b1, MRX_BUF_OFS, 32'h3C);
         apb(1'b1, MRX_CTRL2_OFS, 32'h8);
         rd(MRX_CTRL2_OFS, 32'h8);
      end
      n = 0;
      rdat = 32'h8;
      while (rdat[MRX_BUSY_BIT] !== 1'b0 && n < 300) begin
         apb(1'b0, MRX_STAT_OFS, 32'h0);
         n++;
      end
      if (rdat[MRX_BUSY_BIT] !== 1'b0) begin
         errors++;
         tally_and_finish();
      end
   endtask : rx
   task t_reset();
      rd(MRX_BAUD_OFS, 32'h4);
      rd(MRX_MASK_OFS, 32'h0);
      rd(MRX_CTRL2_OFS, 32'h0);
      rd(MRX_STAT_OFS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, MRX_BAUD_OFS, 32'h3);
   endtask : t_reset
   task t_collide();
      rx(8'hA5, 1'b1);
      rd(MRX_STAT_OFS, 32'h5);
      rd(MRX_IRQ_OFS, 32'h5);
      rd(MRX_CTRL2_OFS, 32'h0);
      chk({31'h0, irq}, 32'h1);
      rd(MRX_BUF_OFS, 32'hA5);
      rd(MRX_STAT_OFS, 32'h4);
      apb(1'b1, MRX_STAT_OFS, 32'h4);
      apb(1'b1, MRX_IRQ_OFS, 32'h7);
      rd(MRX_STAT_OFS, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask : t_collide
   task t_overflow();
      apb(1'b1, MRX_MASK_OFS, 32'h1);
      rx(8'h5A, 1'b0);
      rd(MRX_STAT_OFS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rx(8'hC3, 1'b0);
      rd(MRX_STAT_OFS, 32'h3);
      chk({31'h0, irq}, 32'h1);
      rd(MRX_BUF_OFS, 32'h5A);
      apb(1'b1, MRX_IRQ_OFS, 32'h3);
      apb(1'b1, MRX_MASK_OFS, 32'h0);
      rd(MRX_IRQ_OFS, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask : t_overflow
   task t_misc();
      rd(12'h020, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk({30'h0, scl_out, sda_out}, 32'h0);
      // With the enable low a register write must leave no trace.
      ce <= 1'b0;
      apb(1'b1, MRX_BAUD_OFS, 32'h55);
      ce <= 1'b1;
      rd(MRX_BAUD_OFS, 32'h3);
      apb(1'b1, MRX_CTRL2_OFS, 32'h10);
      rd(MRX_CTRL2_OFS, 32'h10);
      chk({31'h0, ack}, 32'h1);
      apb(1'b1, MRX_CTRL2_OFS, 32'h0);
   endtask : t_misc
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      go = 1'b0;
      ce = 1'b1;
      slv_byte = 8'h00;
      errors = 0;
      n_compared = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_collide();
      t_overflow();
      t_misc();
      tally_and_finish();
   end
endmodule : tb
